// ===== hw/pcinmi_pkg.sv
// package: constants and types for the system-error nmi block
package pcinmi_pkg;
	localparam logic [15:0] PORT_STATUS_CONTROL = 16'h0061;
	localparam logic [15:0] PORT_MASK_CLOCK_IDX = 16'h0070;
	localparam int          SOURCE_FLAG_BIT     = 7;
	localparam int          CLEAR_DISABLE_BIT   = 2;
	localparam int          GLOBAL_MASK_BIT     = 7;
	localparam logic        CLEAR_DISABLE_RST   = 1'b1;
	localparam logic        GLOBAL_MASK_RST     = 1'b1;
	localparam logic [6:0]  CLOCK_INDEX_RST     = 7'h00;
	localparam logic [3:0]  IRQ_LINES_RST       = 4'hF;
	localparam logic [3:0]  SLOT_PIN_BRIDGE     = 4'h1;
	localparam logic [3:0]  SLOT_PIN_NETWORK    = 4'h2;
	localparam logic [3:0]  SLOT_PIN_EXPANSION  = 4'h4;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pcinmi_io_req_type;

	typedef struct packed {
		logic [3:0] bridge;
		logic [3:0] network;
		logic [3:0] expansion;
	} pcinmi_int_pins_type;
endpackage

// ===== hw/pcinmi_sync.sv
// two-stage synchroniser for one level
`timescale 1ns/1ps
module pcinmi_sync
	import pcinmi_pkg::*;
(
	input  wire logic clock,   // system clock
	input  wire logic rst_n,   // async reset, active low
	input  wire logic din,     // asynchronous level
	input  wire logic rst_val, // value held while in reset (constant)
	output logic      dout     // synchronised level
);
	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= din ^ rst_val;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff ^ rst_val;
endmodule // pcinmi_sync

// ===== hw/pcinmi_logic.sv
// system-error nmi path with status and mask ports
`timescale 1ns/1ps
module pcinmi_logic
	import pcinmi_pkg::*;
(
	input  wire logic                clock,        // system clock 20 MHz
	input  wire logic                rst_n,        // async reset, active low
	input  wire pcinmi_io_req_type   io_req,       // i/o read/write strobe
	output logic [7:0]               io_rdata,     // read data, registered
	output logic                     io_rvalid,    // read data valid pulse
	input  wire logic                syserr_n,     // pci system error, low
	input  wire pcinmi_int_pins_type dev_int_n,    // device int lines, low
	output logic [3:0]               chipset_irq_request_lines, // low
	output logic [6:0]               clock_index,  // clock index field
	output logic                     nmi_out       // processor nmi, high
);
	localparam int DEV_LINES = $bits(pcinmi_int_pins_type);

	// decoded accesses
	logic                 sel_status;
	logic                 sel_mask;
	logic                 wr_status;
	logic                 wr_mask;
	logic                 rd_status;

	// pin levels, raw and synchronised
	logic                 syserr_lvl_n;
	logic [DEV_LINES-1:0] dev_int_raw_n;
	logic [DEV_LINES-1:0] dev_int_sync_n;
	pcinmi_int_pins_type  dev_int_lvl_n;

	// register state
	logic                 syserr_source_flag_ff;
	logic                 nxt_flag;
	logic                 syserr_clear_disable_ff;
	logic                 nxt_clear_disable;
	logic                 global_mask_ff;
	logic                 nxt_global_mask;
	logic [6:0]           clock_index_ff;
	logic [6:0]           nxt_clock_index;

	// read path and outputs
	logic [7:0]           status_byte;
	logic [7:0]           io_rdata_ff;
	logic [7:0]           nxt_rdata;
	logic                 io_rvalid_ff;
	logic                 nmi_gate;
	logic                 nmi_out_ff;
	logic [3:0]           irq_lines;
	logic [3:0]           irq_lines_ff;

	pcinmi_sync u_syserr_sync (
		.clock   (clock),
		.rst_n   (rst_n),
		.din     (syserr_n),
		.rst_val (1'b1),
		.dout    (syserr_lvl_n)
	);

	assign dev_int_raw_n = dev_int_n;

	for (genvar i = 0; i < DEV_LINES; i++) begin : g_dev_sync
		pcinmi_sync u_dev_sync (
			.clock   (clock),
			.rst_n   (rst_n),
			.din     (dev_int_raw_n[i]),
			.rst_val (1'b1),
			.dout    (dev_int_sync_n[i])
		);
	end

	assign dev_int_lvl_n = dev_int_sync_n;

	// port address decode
	assign sel_status = (io_req.addr == PORT_STATUS_CONTROL);
	assign sel_mask   = (io_req.addr == PORT_MASK_CLOCK_IDX);
	assign wr_status  = io_req.wr && sel_status;
	assign wr_mask    = io_req.wr && sel_mask;
	assign rd_status  = io_req.rd && sel_status;

	always_comb begin
		nxt_clear_disable = syserr_clear_disable_ff;
		if (wr_status) begin
			nxt_clear_disable = io_req.wdata[CLEAR_DISABLE_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syserr_clear_disable_ff <= CLEAR_DISABLE_RST;
		end else begin
			syserr_clear_disable_ff <= nxt_clear_disable;
		end
	end

	// errors seen while disabled are dropped, so clear wins
	always_comb begin
		nxt_flag = syserr_source_flag_ff;
		if (syserr_clear_disable_ff) begin
			nxt_flag = 1'b0;
		end
		if (!syserr_lvl_n && !syserr_clear_disable_ff) begin
			nxt_flag = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syserr_source_flag_ff <= 1'b0;
		end else begin
			syserr_source_flag_ff <= nxt_flag;
		end
	end

	always_comb begin
		nxt_global_mask = global_mask_ff;
		nxt_clock_index = clock_index_ff;
		if (wr_mask) begin
			nxt_global_mask = io_req.wdata[GLOBAL_MASK_BIT];
			nxt_clock_index = io_req.wdata[6:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			global_mask_ff <= GLOBAL_MASK_RST;
		end else begin
			global_mask_ff <= nxt_global_mask;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clock_index_ff <= CLOCK_INDEX_RST;
		end else begin
			clock_index_ff <= nxt_clock_index;
		end
	end

	always_comb begin
		status_byte                    = 8'h00;
		status_byte[SOURCE_FLAG_BIT]   = syserr_source_flag_ff;
		status_byte[CLEAR_DISABLE_BIT] = syserr_clear_disable_ff;
	end

	// write-only port reads zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_status) begin
			nxt_rdata = status_byte;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_ff <= 8'h00;
		end else begin
			io_rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_rvalid_ff <= 1'b0;
		end else begin
			io_rvalid_ff <= io_req.rd;
		end
	end

	assign nmi_gate = syserr_source_flag_ff && !global_mask_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nmi_out_ff <= 1'b0;
		end else begin
			nmi_out_ff <= nmi_gate;
		end
	end

	assign irq_lines =
		(dev_int_lvl_n.bridge    | ~SLOT_PIN_BRIDGE) &
		(dev_int_lvl_n.network   | ~SLOT_PIN_NETWORK) &
		(dev_int_lvl_n.expansion | ~SLOT_PIN_EXPANSION);

	// registered so the request lines never glitch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_lines_ff <= IRQ_LINES_RST;
		end else begin
			irq_lines_ff <= irq_lines;
		end
	end

	assign io_rdata                  = io_rdata_ff;
	assign io_rvalid                 = io_rvalid_ff;
	assign clock_index               = clock_index_ff;
	assign nmi_out                   = nmi_out_ff;
	assign chipset_irq_request_lines = irq_lines_ff;
endmodule // pcinmi_logic

// ===== testbench/pcinmi_chk.sv
// checker for the system-error nmi block
`timescale 1ns/1ps
module pcinmi_chk
	import pcinmi_pkg::*;
(
	input wire logic                clock,     // clk
	input wire logic                rst_n,     // reset
	input wire pcinmi_io_req_type   io_req,    // req
	input wire logic [7:0]          io_rdata,  // data
	input wire logic                io_rvalid, // valid
	input wire logic                syserr_n,  // error
	input wire pcinmi_int_pins_type dev_int_n, // lines
	input wire logic [3:0]          chipset_irq_request_lines, // irq
	input wire logic [6:0]          clock_index, // index
	input wire logic                nmi_out    // nmi
);
	logic mask_ff, dis_ff;
	wire r61 = io_req.rd && io_req.addr == PORT_STATUS_CONTROL;
	wire w61 = io_req.wr && io_req.addr == PORT_STATUS_CONTROL;
	wire w70 = io_req.wr && io_req.addr == PORT_MASK_CLOCK_IDX;
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) mask_ff <= 1'b1; else if (w70) mask_ff <= io_req.wdata[7];
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n) dis_ff <= 1'b1; else if (w61) dis_ff <= io_req.wdata[2];
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_err; (!syserr_n && !mask_ff && !dis_ff)[*4]; endsequence
	sequence s_dis_rd; dis_ff[*3] ##0 r61; endsequence
	a_rd_valid: assert property (io_req.rd |=> io_rvalid) else $error("a");
	a_rv_cause: assert property (io_rvalid |-> $past(io_req.rd)) else $error("b");
	a_wo_zero: assert property (io_req.rd && !r61 |=> io_rdata == 8'h00)
		else $error("c");
	a_pin_route: assert property (chipset_irq_request_lines ==
		{1'h1, $past(dev_int_n.expansion[2], 3),
		$past(dev_int_n.network[1], 3), $past(dev_int_n.bridge[0], 3)})
		else $error("irq line routing wrong");
	a_index_wr: assert property (w70 |=> clock_index == $past(io_req.wdata[6:0]))
		else $error("e");
	a_mask_block: assert property (mask_ff[*3] |-> !nmi_out) else $error("f");
	a_err_nmi: assert property (s_err |=> nmi_out) else $error("g");
	a_flag_clr: assert property (s_dis_rd |=> io_rdata == 8'h04) else $error("h");
endmodule // pcinmi_chk
bind pcinmi_logic pcinmi_chk u_chk (.*);

// ===== testbench/pcinmi_host.sv
// host model counting nmi events
`timescale 1ns/1ps
module pcinmi_host (
	input wire logic  clock,    // clk
	input wire logic  rst_n,    // reset
	input wire logic  nmi_out,  // nmi
	output logic [1:0] nmi_seen // count
);
	logic last_ff;
	always_ff @(posedge clock) last_ff <= nmi_out;
	always_ff @(posedge clock)
		nmi_seen <= rst_n ? nmi_seen + 2'(nmi_out & ~last_ff) : 2'h0;
endmodule // pcinmi_host

// ===== testbench/tb.sv
// testbench for the system-error nmi block
`timescale 1ns/1ps
module tb
	import pcinmi_pkg::*;
;
	logic clock = 1'b0, rst_n = 1'b0, syserr_n = 1'b1, io_rvalid, nmi_out;
	pcinmi_io_req_type io_req = '0;
	pcinmi_int_pins_type dev_int_n = 12'hFFF;
	logic [7:0] io_rdata;
	logic [3:0] chipset_irq_request_lines;
	logic [6:0] clock_index;
	logic [1:0] nmi_seen;
	int n_errors = 0, tests_run = 0;
	always #25 clock = ~clock;
	pcinmi_logic u_dut (
		.clock                     (clock),
		.rst_n                     (rst_n),
		.io_req                    (io_req),
		.io_rdata                  (io_rdata),
		.io_rvalid                 (io_rvalid),
		.syserr_n                  (syserr_n),
		.dev_int_n                 (dev_int_n),
		.chipset_irq_request_lines (chipset_irq_request_lines),
		.clock_index               (clock_index),
		.nmi_out                   (nmi_out)
	);
	pcinmi_host u_host (
		.clock    (clock),
		.rst_n    (rst_n),
		.nmi_out  (nmi_out),
		.nmi_seen (nmi_seen)
	);
	task automatic chk(input logic ok);
		tests_run++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t check", $time);
		end
	endtask
	task automatic io(input logic r, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock) io_req <= '{r, !r, a, d};
		@(posedge clock) io_req <= '0;
		#1;
		if (r) chk(io_rvalid === 1'b1 && io_rdata === d);
	endtask
	task automatic err(input logic e);
		@(posedge clock) syserr_n <= 1'b0;
		repeat (6) @(posedge clock);
		#1 chk(nmi_out === e);
		@(posedge clock) syserr_n <= 1'b1;
	endtask
	task automatic t_nmi;
		io(1'b1, PORT_STATUS_CONTROL, 8'h04);
		io(1'b0, PORT_MASK_CLOCK_IDX, 8'h05);
		chk(clock_index === 7'h05);
		io(1'b1, PORT_MASK_CLOCK_IDX, 8'h00);
		io(1'b0, PORT_STATUS_CONTROL, 8'h00);
		err(1'b1);
		chk(nmi_seen === 2'h1);
		io(1'b1, PORT_STATUS_CONTROL, 8'h80);
	endtask
	task automatic t_clear;
		io(1'b0, PORT_STATUS_CONTROL, 8'h04);
		repeat (2) @(posedge clock);
		io(1'b1, PORT_STATUS_CONTROL, 8'h04);
		chk(nmi_out === 1'b0);
		io(1'b0, PORT_STATUS_CONTROL, 8'h00);
		io(1'b1, PORT_STATUS_CONTROL, 8'h00);
	endtask
	task automatic t_pins;
		@(posedge clock) dev_int_n <= 12'hEFF;
		repeat (4) @(posedge clock);
		#1 chk(chipset_irq_request_lines === 4'hE);
		@(posedge clock) dev_int_n <= 12'h1DB;
		repeat (4) @(posedge clock);
		#1 chk(chipset_irq_request_lines === 4'h9);
	endtask
	task automatic t_mask;
		io(1'b0, PORT_MASK_CLOCK_IDX, 8'h80);
		@(posedge clock) dev_int_n <= 12'h000;
		err(1'b0);
		chk(chipset_irq_request_lines === 4'h8);
		io(1'b1, PORT_STATUS_CONTROL, 8'h80);
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_nmi;
		t_clear;
		t_pins;
		t_mask;
		summarize;
	end
	initial begin
		#100000;
		n_errors++;
		summarize;
	end
endmodule // tb
